// ===== core/spc_cfg.svh
// Purpose: Constants of the speech playback command control block
// Assumes: 20 MHz clock, byte commands written through the register port
// Notes: Definitions only
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define SPC_OFS_CMD 4'h0
`define SPC_OFS_STATUS 4'h4
`define SPC_OFS_PHRASE 4'h8
`define SPC_OFS_VOLUME 4'hc

// ****************************************
// Command encodings
// ****************************************
`define SPC_OP_SELECT 4'h3
`define SPC_BYTE_BEGIN 8'h50
`define SPC_BYTE_SILENCE 8'h70
`define SPC_BYTE_REP_SET 8'h80
`define SPC_BYTE_REP_CLR 8'h90
`define SPC_BYTE_COARSE 8'h40
`define SPC_BYTE_FINE 8'h08

// ****************************************
// Widths, reset values and decode limits
// ****************************************
`define SPC_PHRASE_W 10
`define SPC_COARSE_W 5
`define SPC_FINE_W 6
`define SPC_DATA_W 16
`define SPC_COARSE_RST 5'h00
`define SPC_COARSE_MUTE 5'h1f
`define SPC_FINE_RST 6'h23
`define SPC_FINE_MUTE_MAX 6'h0e

// ****************************************
// Timing
// ****************************************
`define SPC_CLK_KHZ 20000
`define SPC_STEP_MS 4
`define SPC_ADDR_CYC 20
`endif

// ===== core/spc_pkg.sv
// Purpose: Types of the speech playback command control block
// Assumes: spc_cfg.svh provides widths
// Notes: Module state is two packed structs, reset release and registers
`include "spc_cfg.svh"
package spc_pkg;

   // ****************************************
   // Sequencer states, one-hot
   // ****************************************
   typedef enum logic [3:0] {
      SPC_IDLE = 4'h1,
      SPC_ADDR = 4'h2,
      SPC_DIRECT_CMD_A = 4'h4,
      SPC_SIL = 4'h8
   } spc_state_type;

   // ****************************************
   // Register state of the top module
   // ****************************************
   typedef struct packed {
      logic rst1;
      logic rst2;
   } spc_rst_type;

   typedef struct packed {
      spc_state_type st;
      logic second;
      logic [7:0] op;
      logic [`SPC_PHRASE_W-1:0] phrase;
      logic [7:0] sil_len;
      logic pend_sil;
      logic pend_direct_cmd_a;
      logic repeat_on;
      logic [`SPC_COARSE_W-1:0] coarse;
      logic [`SPC_FINE_W-1:0] fine;
      logic [7:0] addr_cnt;
      logic [16:0] step_cnt;
      logic [7:0] sil_cnt;
      logic accept;
      logic active_n;
      logic busy_n;
      logic start;
      logic coarse_mute;
      logic fine_mute;
      logic [`SPC_DATA_W-1:0] rdata;
   } spc_regs_type;

endpackage

// ===== core/spc_top.sv
// Purpose: Command interpreter for phrase playback, silence, repeat and volume
// Assumes: Command bytes arrive one per write to the command offset
// Notes: Playback engine reports phrase end and power events on the same clock
// Notes on behaviour
// - Phrase select is two bytes: 0011, address 9:8, 00; then address 7:0
// - Phrase select stores the ten-bit address only; playback waits for begin
// - Power-down clears the stored phrase address
// - Begin byte 50h starts the stored phrase; host selects first
// - Silence insert is 70h then length; host sends it while accept high
// - Silence lasts length plus one times 4 ms
// - After silence insert accept stays low until phrase ends, then rises
// - Direct_cmd_a during silence drops accept until the queued phrase starts
// - Playback active stays low through a whole chained sequence
// - Repeat set is 80h, valid during playback while accept is high
// - Repeat mode replays the phrase and holds accept low
// - Halt leaves repeat mode
// - Repeat clear is 90h, exits repeat mode and raises accept
// - Coarse volume is two bytes, 5-bit code, refused during power events
// - Coarse code 00 is 0 dB rising attenuation, 1F mutes
// - Coarse code returns to 0 dB at reset and at power-up
// - Fine gain is 08h then 6-bit code, refused during power events
// - Fine code 3F is +12 dB downward, 0E and below mute
// - Fine code resets to 23h, kept over halt, reset at power-down
// - Accept is low while handling a command or phrase address; select and volume bytes do not drop accept here
// - Playback active is low while handling a command or playing
//
// Added by the designer: strobed register access and the placing of the registers.
`include "spc_cfg.svh"
module spc_top #(
   parameter int STEP_CYC = `SPC_STEP_MS * `SPC_CLK_KHZ,
   parameter int ADDR_CYC = `SPC_ADDR_CYC
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [3:0] addr_i,
   input wire logic [`SPC_DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [`SPC_DATA_W-1:0] rdata_o,
   input wire logic phrase_done_i,
   input wire logic halt_i,
   input wire logic power_down_i,
   input wire logic power_up_i,
   input wire logic power_busy_i,
   output logic direct_cmd_a_start_o,
   output logic [`SPC_PHRASE_W-1:0] direct_cmd_a_addr_o,
   output logic silence_on_o,
   output logic cmd_accept_o,
   output logic playback_active_n_o,
   output logic cmd_busy_n_o,
   output logic [`SPC_COARSE_W-1:0] coarse_vol_code_o,
   output logic [`SPC_FINE_W-1:0] fine_gain_code_o,
   output logic coarse_mute_o,
   output logic fine_mute_o
);

   // ****************************************
   // Reset release
   // ****************************************
   spc_pkg::spc_rst_type rst_q;
   logic rst_n;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_q <= '0;
      end
      else
      begin
         rst_q <= {1'b1, rst_q.rst1};
      end
   end
   assign rst_n = rst_q.rst2;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic fine_is_mute(input logic [`SPC_FINE_W-1:0] c);
      fine_is_mute = (c <= `SPC_FINE_MUTE_MAX);
   endfunction

   function automatic logic coarse_is_mute(input logic [`SPC_COARSE_W-1:0] c);
      coarse_is_mute = (c == `SPC_COARSE_MUTE);
   endfunction

   // ****************************************
   // State
   // ****************************************
   spc_pkg::spc_regs_type r_q;
   spc_pkg::spc_regs_type r_d;
   logic cmd_wr;
   logic [7:0] b;
   logic first;
   logic sil_last;

   assign cmd_wr = wr_i && (addr_i == `SPC_OFS_CMD);
   assign b = wdata_i[7:0];
   assign first = cmd_wr && !r_q.second;
   assign sil_last = (r_q.step_cnt == 17'(STEP_CYC - 1)) && (r_q.sil_cnt == 8'h00);

   always_comb
   begin
      r_d = r_q;
      r_d.start = 1'b0;
      r_d.rdata = '0;
      // Byte decode
      if (first)
      begin
         r_d.op = b;
         if ((b[7:4] == `SPC_OP_SELECT && b[1:0] == 2'b00) || b == `SPC_BYTE_SILENCE ||
             b == `SPC_BYTE_COARSE || b == `SPC_BYTE_FINE)
         begin
            r_d.second = 1'b1;
         end
         else if (b == `SPC_BYTE_BEGIN)
         begin
            if (r_q.st == spc_pkg::SPC_IDLE)
            begin
               r_d.st = spc_pkg::SPC_ADDR;
               r_d.addr_cnt = '0;
            end
            else if (r_q.st == spc_pkg::SPC_DIRECT_CMD_A && r_q.accept)
            begin
               r_d.pend_direct_cmd_a = 1'b1;
            end
            else if (r_q.st == spc_pkg::SPC_SIL)
            begin
               r_d.pend_direct_cmd_a = 1'b1;
            end
         end
         else if (b == `SPC_BYTE_REP_SET && r_q.st == spc_pkg::SPC_DIRECT_CMD_A && r_q.accept)
         begin
            r_d.repeat_on = 1'b1;
         end
         else if (b == `SPC_BYTE_REP_CLR)
         begin
            r_d.repeat_on = 1'b0;
         end
         // Other first bytes are ignored
      end
      else if (cmd_wr)
      begin
         r_d.second = 1'b0;
         if (r_q.op[7:4] == `SPC_OP_SELECT)
         begin
            r_d.phrase = {r_q.op[3:2], b};
         end
         else if (r_q.op == `SPC_BYTE_SILENCE && r_q.st == spc_pkg::SPC_DIRECT_CMD_A && r_q.accept)
         begin
            r_d.sil_len = b;
            r_d.pend_sil = 1'b1;
         end
         else if (r_q.op == `SPC_BYTE_COARSE && !power_busy_i)
         begin
            r_d.coarse = b[4:0];
         end
         else if (r_q.op == `SPC_BYTE_FINE && !power_busy_i)
         begin
            r_d.fine = b[5:0];
         end
      end
      // Sequencer
      case (r_q.st)
         spc_pkg::SPC_IDLE:
         begin
            r_d.pend_direct_cmd_a = 1'b0;
            r_d.pend_sil = 1'b0;
         end
         spc_pkg::SPC_ADDR:
         begin
            r_d.addr_cnt = r_q.addr_cnt + 8'h01;
            if (r_q.addr_cnt == 8'(ADDR_CYC - 1))
            begin
               r_d.st = spc_pkg::SPC_DIRECT_CMD_A;
               r_d.start = 1'b1;
            end
         end
         spc_pkg::SPC_DIRECT_CMD_A:
         begin
            if (phrase_done_i)
            begin
               if (r_d.repeat_on)
               begin
                  r_d.start = 1'b1;
               end
               else if (r_d.pend_sil)
               begin
                  r_d.st = spc_pkg::SPC_SIL;
                  r_d.pend_sil = 1'b0;
                  r_d.step_cnt = '0;
                  r_d.sil_cnt = r_d.sil_len;
               end
               else if (r_d.pend_direct_cmd_a)
               begin
                  r_d.pend_direct_cmd_a = 1'b0;
                  r_d.start = 1'b1;
               end
               else
               begin
                  r_d.st = spc_pkg::SPC_IDLE;
               end
            end
         end
         spc_pkg::SPC_SIL:
         begin
            r_d.step_cnt = r_q.step_cnt + 17'h00001;
            if (r_q.step_cnt == 17'(STEP_CYC - 1))
            begin
               r_d.step_cnt = '0;
               r_d.sil_cnt = r_q.sil_cnt - 8'h01;
            end
            if (sil_last)
            begin
               if (r_d.pend_direct_cmd_a)
               begin
                  r_d.st = spc_pkg::SPC_DIRECT_CMD_A;
                  r_d.pend_direct_cmd_a = 1'b0;
                  r_d.start = 1'b1;
               end
               else
               begin
                  r_d.st = spc_pkg::SPC_IDLE;
               end
            end
         end
         default:
         begin
            r_d.st = spc_pkg::SPC_IDLE;
         end
      endcase
      // Halt and power events take priority
      if (halt_i || power_down_i)
      begin
         r_d.st = spc_pkg::SPC_IDLE;
         r_d.repeat_on = 1'b0;
         r_d.pend_direct_cmd_a = 1'b0;
         r_d.pend_sil = 1'b0;
         r_d.start = 1'b0;
      end
      if (power_down_i)
      begin
         r_d.phrase = '0;
         r_d.fine = `SPC_FINE_RST;
      end
      if (power_up_i)
      begin
         r_d.coarse = `SPC_COARSE_RST;
      end
      // Status outputs
      r_d.accept = (r_d.st == spc_pkg::SPC_IDLE) ||
                   (r_d.st == spc_pkg::SPC_DIRECT_CMD_A && !r_d.repeat_on && !r_d.pend_sil && !r_d.pend_direct_cmd_a) ||
                   (r_d.st == spc_pkg::SPC_SIL && !r_d.pend_direct_cmd_a);
      r_d.active_n = (r_d.st == spc_pkg::SPC_IDLE) && !cmd_wr;
      r_d.busy_n = (r_d.st != spc_pkg::SPC_ADDR);
      r_d.coarse_mute = coarse_is_mute(r_d.coarse);
      r_d.fine_mute = fine_is_mute(r_d.fine);
      // Register reads
      if (rd_i)
      begin
         case (addr_i)
            `SPC_OFS_STATUS:
               r_d.rdata = {8'h00, r_q.st, r_q.repeat_on, r_q.busy_n, r_q.active_n, r_q.accept};
            `SPC_OFS_PHRASE:
               r_d.rdata = 16'(r_q.phrase);
            `SPC_OFS_VOLUME:
               r_d.rdata = {5'h00, r_q.coarse, r_q.fine};
            default:
               r_d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r_q <= '0;
         r_q.st <= spc_pkg::SPC_IDLE;
         r_q.coarse <= `SPC_COARSE_RST;
         r_q.fine <= `SPC_FINE_RST;
         r_q.accept <= 1'b1;
         r_q.active_n <= 1'b1;
         r_q.busy_n <= 1'b1;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign rdata_o = r_q.rdata;
   assign direct_cmd_a_start_o = r_q.start;
   assign direct_cmd_a_addr_o = r_q.phrase;
   // One-hot silence bit of the state register
   assign silence_on_o = r_q.st[3];
   assign cmd_accept_o = r_q.accept;
   assign playback_active_n_o = r_q.active_n;
   assign cmd_busy_n_o = r_q.busy_n;
   assign coarse_vol_code_o = r_q.coarse;
   assign fine_gain_code_o = r_q.fine;
   assign coarse_mute_o = r_q.coarse_mute;
   assign fine_mute_o = r_q.fine_mute;

   // ****************************************
   // Checks
   // ****************************************
   logic [31:0] sil_cyc_q;
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sil_cyc_q <= '0;
      end
      else
      begin
         sil_cyc_q <= silence_on_o ? sil_cyc_q + 32'h1 : 32'h0;
      end
   end

   sequence begin_from_idle_s;
      first && b == `SPC_BYTE_BEGIN && r_q.st == spc_pkg::SPC_IDLE && !halt_i && !power_down_i;
   endsequence

   sequence start_after_addr_s;
      !cmd_busy_n_o ##[0:299] (direct_cmd_a_start_o || halt_i || power_down_i);
   endsequence

   phrase_store_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      cmd_wr && r_q.second && r_q.op[7:4] == `SPC_OP_SELECT && !power_down_i
      |=> direct_cmd_a_addr_o == {$past(r_q.op[3:2]), $past(b)} && !direct_cmd_a_start_o)
      else $error("Phrase select not stored");
   power_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      power_down_i |=> direct_cmd_a_addr_o == '0 && fine_gain_code_o == `SPC_FINE_RST)
      else $error("Power-down did not reinitialise");
   begin_start_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      begin_from_idle_s |=> start_after_addr_s)
      else $error("Begin did not start playback");
   silence_len_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      $fell(silence_on_o) && !$past(halt_i) && !$past(power_down_i)
      |-> $past(sil_cyc_q) == ($past(r_q.sil_len, 2) + 32'h1) * STEP_CYC - 1)
      else $error("Silence length wrong");
   silence_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      r_q.pend_sil && r_q.st == spc_pkg::SPC_DIRECT_CMD_A |-> !cmd_accept_o)
      else $error("Accept high while silence pending");
   repeat_low_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      r_q.repeat_on |-> !cmd_accept_o && !playback_active_n_o)
      else $error("Accept high in repeat mode");
   halt_repeat_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      halt_i |=> !r_q.repeat_on && r_q.st == spc_pkg::SPC_IDLE)
      else $error("Halt kept repeat mode");
   repeat_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      first && b == `SPC_BYTE_REP_CLR && r_q.st == spc_pkg::SPC_DIRECT_CMD_A && !phrase_done_i && !r_q.pend_sil
      && !r_q.pend_direct_cmd_a
      && !halt_i && !power_down_i |=> cmd_accept_o)
      else $error("Repeat clear left accept low");
   chain_busy_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      r_q.st == spc_pkg::SPC_SIL |-> !playback_active_n_o)
      else $error("Active released during silence");
   coarse_init_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      power_up_i |=> coarse_vol_code_o == `SPC_COARSE_RST)
      else $error("Coarse volume not reinitialised");

endmodule

// ===== test/spc_engine_model.sv
// Purpose: Playback engine stand-in facing the command block
// Assumes: Each start plays a phrase of len_i plus one cycles
// Notes: Halt drops a running phrase without a done pulse
module spc_engine_model (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic start_i,
   input wire logic halt_i,
   input wire logic [7:0] len_i,
   output logic done_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic run_q;
   logic [7:0] cnt_q;
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         run_q <= 1'b0;
         cnt_q <= 8'h00;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= run_q && cnt_q == 8'h00 && !halt_i && !start_i;
         if (halt_i)
            run_q <= 1'b0;
         else if (start_i)
         begin
            run_q <= 1'b1;
            cnt_q <= len_i;
         end
         else if (run_q && cnt_q == 8'h00)
            run_q <= 1'b0;
         else
            cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule

// ===== test/spc_top_tb.sv
// Purpose: Self-checking bench of the command block
// Assumes: Short silence step of 10 cycles
// Notes: Engine model answers phrase starts
`include "spc_cfg.svh"
module spc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int STEP = 10;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0, rd_i = 1'b0, halt_i = 1'b0;
   logic power_down_i = 1'b0, power_up_i = 1'b0, power_busy_i = 1'b0;
   logic phrase_done_i, direct_cmd_a_start_o, silence_on_o, cmd_accept_o, playback_active_n_o, cmd_busy_n_o;
   logic coarse_mute_o, fine_mute_o;
   logic [15:0] rdata_o, d;
   logic [9:0] direct_cmd_a_addr_o, pa;
   logic [4:0] coarse_vol_code_o, cv;
   logic [5:0] fine_gain_code_o, fg;
   logic [7:0] eng_len = 8'd80;
   logic [7:0] sl;
   logic track = 1'b0;
   logic [7:0] unk_bytes [3] = '{8'ha0, 8'hf5, 8'h0a};
   int mismatches = 0;
   int comparisons = 0;
   int sil_cyc = 0;
   int gaps = 0;
   int starts = 0;

   always #25 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      if (silence_on_o === 1'b1) sil_cyc++;
      if (direct_cmd_a_start_o === 1'b1) starts++;
      if (track && playback_active_n_o !== 1'b0) gaps++;
   end

   spc_top #(.STEP_CYC(STEP), .ADDR_CYC(20)) u_spc_top (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .phrase_done_i(phrase_done_i),
      .halt_i(halt_i), .power_down_i(power_down_i), .power_up_i(power_up_i), .power_busy_i(power_busy_i),
      .direct_cmd_a_start_o(direct_cmd_a_start_o), .direct_cmd_a_addr_o(direct_cmd_a_addr_o), .silence_on_o(silence_on_o),
      .cmd_accept_o(cmd_accept_o), .playback_active_n_o(playback_active_n_o), .cmd_busy_n_o(cmd_busy_n_o),
      .coarse_vol_code_o(coarse_vol_code_o), .fine_gain_code_o(fine_gain_code_o),
      .coarse_mute_o(coarse_mute_o), .fine_mute_o(fine_mute_o));
   spc_engine_model u_spc_engine_model (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(direct_cmd_a_start_o),
      .halt_i(halt_i), .len_i(eng_len), .done_o(phrase_done_i));

   // ****************************************
   // Bus, compare and wait tasks
   // ****************************************
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk_reg(logic [15:0] got, logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(logic got, logic exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [15:0] v);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic cmd(logic [7:0] b);
      wr(`SPC_OFS_CMD, {8'h00, b});
   endtask
   task automatic rd(logic [3:0] a, output logic [15:0] v);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
      v = rdata_o;
   endtask
   task automatic pulse(int w);
      halt_i <= (w == 0);
      power_down_i <= (w == 1);
      power_up_i <= (w == 2);
      @(posedge clk_i);
      {halt_i, power_down_i, power_up_i} <= 3'b000;
      @(posedge clk_i);
   endtask
   function automatic logic pick(int w);
      case (w)
         0: return direct_cmd_a_start_o;
         1: return silence_on_o;
         2: return phrase_done_i;
         default: return playback_active_n_o;
      endcase
   endfunction
   task automatic wait_for(int w, int n);
      int i;
      for (i = 0; i < n; i++)
      begin
         @(posedge clk_i);
         if (pick(w) === 1'b1) break;
      end
      if (i == n)
      begin
         mismatches++;
         $display("Error at %0t: wait %0d timed out", $time, w);
         end_sim();
      end
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      void'($urandom(32'ha19aa7d2));
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(`SPC_OFS_STATUS, d);
      chk_reg(d, 16'h0017);
      rd(`SPC_OFS_VOLUME, d);
      chk_reg(d, 16'h0023);
      pa = 10'($urandom);
      cmd({`SPC_OP_SELECT, pa[9:8], 2'b00});
      cmd(pa[7:0]);
      foreach (unk_bytes[k]) cmd(unk_bytes[k]);
      rd(`SPC_OFS_PHRASE, d);
      chk_reg(d, {6'h00, pa});
      rd(`SPC_OFS_STATUS, d);
      chk_reg(d, 16'h0017);
      chk_reg(16'(starts), 16'h0000);
      $display("test select done");
      cmd(`SPC_BYTE_BEGIN);
      chk_flag(cmd_busy_n_o, 1'b0);
      chk_flag(cmd_accept_o, 1'b0);
      chk_flag(playback_active_n_o, 1'b0);
      wait_for(0, 40);
      chk_reg({6'h00, direct_cmd_a_addr_o}, {6'h00, pa});
      chk_flag(cmd_accept_o, 1'b1);
      track <= 1'b1;
      cmd(`SPC_BYTE_BEGIN);
      chk_flag(cmd_accept_o, 1'b0);
      wait_for(2, 200);
      wait_for(0, 3);
      chk_flag(cmd_busy_n_o, 1'b1);
      sl = 8'(4 + $urandom_range(0, 12));
      sil_cyc = 0;
      cmd(`SPC_BYTE_SILENCE);
      cmd(sl);
      chk_flag(cmd_accept_o, 1'b0);
      wait_for(2, 200);
      wait_for(1, 3);
      chk_flag(cmd_accept_o, 1'b1);
      cmd(`SPC_BYTE_BEGIN);
      chk_flag(cmd_accept_o, 1'b0);
      wait_for(0, 300);
      chk_reg(16'(sil_cyc), 16'((sl + 1) * STEP));
      chk_flag(cmd_accept_o, 1'b1);
      wait_for(2, 200);
      track <= 1'b0;
      wait_for(3, 4);
      chk_reg(16'(gaps), 16'h0000);
      $display("test chain done");
      eng_len <= 8'd6;
      cmd(`SPC_BYTE_BEGIN);
      wait_for(0, 40);
      cmd(`SPC_BYTE_REP_SET);
      chk_flag(cmd_accept_o, 1'b0);
      wait_for(0, 20);
      wait_for(0, 20);
      chk_flag(cmd_accept_o, 1'b0);
      cmd(`SPC_BYTE_REP_CLR);
      chk_flag(cmd_accept_o, 1'b1);
      wait_for(3, 40);
      cmd(`SPC_BYTE_BEGIN);
      wait_for(0, 40);
      cmd(`SPC_BYTE_REP_SET);
      pulse(0);
      rd(`SPC_OFS_STATUS, d);
      chk_reg(d, 16'h0017);
      $display("test repeat done");
      for (int k = 0; k < 6; k++)
      begin
         cv = (k == 0) ? 5'h1f : (k == 1) ? 5'h1e : 5'($urandom);
         fg = (k == 0) ? 6'h0e : (k == 1) ? 6'h0f : (k == 2) ? 6'h3f : 6'($urandom);
         cmd(`SPC_BYTE_COARSE);
         cmd({3'b000, cv});
         cmd(`SPC_BYTE_FINE);
         cmd({2'b00, fg});
         rd(`SPC_OFS_VOLUME, d);
         chk_reg(d, {5'h00, cv, fg});
         chk_reg({11'h000, coarse_vol_code_o}, {11'h000, cv});
         chk_flag(coarse_mute_o, cv == 5'h1f);
         chk_flag(fine_mute_o, fg <= 6'h0e);
      end
      power_busy_i <= 1'b1;
      cmd(`SPC_BYTE_COARSE);
      cmd({3'b000, ~cv});
      cmd(`SPC_BYTE_FINE);
      cmd({2'b00, ~fg});
      power_busy_i <= 1'b0;
      rd(`SPC_OFS_VOLUME, d);
      chk_reg(d, {5'h00, cv, fg});
      $display("test volume done");
      pulse(1);
      rd(`SPC_OFS_PHRASE, d);
      chk_reg(d, 16'h0000);
      rd(`SPC_OFS_VOLUME, d);
      chk_reg(d & 16'h003f, 16'h0023);
      pulse(2);
      rd(`SPC_OFS_VOLUME, d);
      chk_reg(d, 16'h0023);
      $display("test power done");
      end_sim();
   end
endmodule
